// *** core/bridge_adc_serial_port.sv ***
// Serial port and conversion timing of a bridge transducer converter.
// Assumes pins are asynchronous to clk and sampled at 250 MHz, the serial
// clock idles low between frames, and software feeds raw samples.
//
// Functional notes
// - Reset restores calibration registers, command mode
// - Four-wire mode: deselected output is tri-stated
// - Host serial clock paces all shifting
// - Serial input ignored outside clocked words
// - Mode pin low: 4/5-wire, high: 3-wire
// - Conversion mode: data ready low every period; here only while a conversion read waits
// - Data ready high: read, update, calibration, sleep
// - Output carries conversion or calibration per command
// - Four-wire mode: output tri-stated unless transmitting
// - Bipolar mid-scale code is the top bit alone
// - Polarity bit low unipolar, high bipolar
// - Filter reset restarts after 24th clock fall
// - Sleep bit stops conversions, resets to awake
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/100ps
`include "bridge_adc_defines.svh"
module bridge_adc_serial_port #(
    parameter int unsigned CONV_PERIOD = `CONV_PERIOD,
    parameter int unsigned RES         = `RES_BITS
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        sclk,
    input  wire logic        chip_select_n,
    input  wire logic        serial_in,
    input  wire logic        master_clock_in,
    input  wire logic        port_wire_mode,
    output logic             serial_out,
    output logic             serial_out_oe_n,
    output logic             data_ready_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic      [31:0] reg_rdata,
    output logic             irq
);

    localparam int unsigned CW = $clog2(CONV_PERIOD);
    localparam int unsigned WB = `WORD_BITS;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    link_pins_if #(.WIDTH(`PIN_COUNT)) pins ();

    pin_sync #(
        .WIDTH (`PIN_COUNT)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .raw  ({port_wire_mode, master_clock_in, serial_in,
                chip_select_n, sclk}),
        .pins (pins)
    );

    logic sclk_rise;
    logic sclk_fall;
    logic mclk_rise;
    logic sin_level;
    logic three_wire;
    logic selected;

    assign sclk_rise  = pins.rise[`PIN_SCLK];
    assign sclk_fall  = pins.fall[`PIN_SCLK];
    assign mclk_rise  = pins.rise[`PIN_MCLK];
    assign sin_level  = pins.level[`PIN_SIN];
    assign three_wire = pins.level[`PIN_MODE];
    // Three-wire mode has no select pin: the port is always addressed
    assign selected   = three_wire | ~pins.level[`PIN_SEL_N];

    ////////////////////////////////////////////////////////////////////////
    // State declarations

    bridge_adc_pkg::port_state_type state_reg;

    logic [4:0]      bit_cnt_reg;
    logic [WB-1:0]   rx_reg;
    logic [WB-1:0]   tx_reg;
    logic [2:0]      sel_reg;
    logic            rd_conv_reg;
    logic [WB-1:0]   cal_reg [1:6];
    logic [CW-1:0]   conv_cnt_reg;
    logic [WB-1:0]   word_reg;
    logic            fresh_reg;
    logic            data_ready_n_n_reg;
    logic [RES-1:0]  sample_reg;
    logic [`EVT_COUNT-1:0] status_reg;
    logic [`EVT_COUNT-1:0] mask_reg;
    logic [`EVT_COUNT-1:0] events;

    logic [3:0] cfg;
    logic       asleep;
    logic       filter_hold;
    logic       cal_busy;
    logic       running;
    logic       load_evt;
    logic       take;
    logic       cmd_done;
    logic [7:0] cmd_word;
    logic       wr_commit;
    logic       rd_done;

    assign cfg         = cal_reg[`SEL_CONFIG][3:0];
    assign asleep      = cfg[`CFG_SLEEP];
    assign filter_hold = cfg[`CFG_FILTER_RESET];
    assign cal_busy    = cfg[`CFG_CAL_RUN];
    assign running     = ~asleep & ~filter_hold & ~cal_busy;

    ////////////////////////////////////////////////////////////////////////
    // Output coding

    function automatic logic [WB-1:0] code_word(
        input logic [RES-1:0] raw,
        input logic           bipolar
    );
        logic [RES-1:0] c;
        c = '0;
        if (bipolar) begin
            // Offset binary: zero input lands on the top bit alone
            c = {~raw[RES-1], raw[RES-2:0]};
        end else if (!raw[RES-1]) begin
            c = {raw[RES-2:0], 1'b0};
        end
        return {c, {(WB-RES){1'b0}}};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Conversion timing on master clock edges

    assign load_evt = running & mclk_rise
                    & (conv_cnt_reg == CW'(CONV_PERIOD - 1));

    // Counter sits at zero while held, so counting restarts on the first
    // master clock rise after the filter reset bit is cleared
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conv_cnt_reg <= '0;
        end else if (!running) begin
            conv_cnt_reg <= '0;
        end else if (mclk_rise) begin
            if (load_evt) begin
                conv_cnt_reg <= '0;
            end else begin
                conv_cnt_reg <= conv_cnt_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word_reg <= '0;
        end else if (load_evt) begin
            word_reg <= code_word(sample_reg, cfg[`CFG_POLARITY]);
        end
    end

    // A word waiting for the reader; a new load wins over its consumption
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fresh_reg <= 1'b0;
        end else if (load_evt) begin
            fresh_reg <= 1'b1;
        end else if (take || !running) begin
            fresh_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial sequencer

    assign cmd_word  = {rx_reg[6:0], sin_level};
    assign cmd_done  = (state_reg == bridge_adc_pkg::ST_CMD) & selected
                     & sclk_rise & (bit_cnt_reg == 5'(`CMD_BITS - 1));
    // Commit on the fall of the last data clock of the word
    assign wr_commit = (state_reg == bridge_adc_pkg::ST_WR) & selected
                     & sclk_fall & (bit_cnt_reg == 5'(WB));
    assign rd_done   = (state_reg == bridge_adc_pkg::ST_RD) & selected
                     & sclk_fall & (bit_cnt_reg == 5'(WB));
    assign take      = fresh_reg & running & ~load_evt
                     & ((state_reg == bridge_adc_pkg::ST_WAIT)
                       | ((state_reg == bridge_adc_pkg::ST_RD)
                         & rd_conv_reg & (bit_cnt_reg == 5'd0)));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg   <= bridge_adc_pkg::ST_CMD;
            bit_cnt_reg <= '0;
            rx_reg      <= '0;
            tx_reg      <= '0;
            sel_reg     <= '0;
            rd_conv_reg <= 1'b0;
        end else if (take) begin
            state_reg   <= bridge_adc_pkg::ST_RD;
            bit_cnt_reg <= '0;
            tx_reg      <= word_reg;
        end else if (!selected
                     && state_reg != bridge_adc_pkg::ST_WAIT) begin
            // Deselect abandons a partial word
            state_reg   <= bridge_adc_pkg::ST_CMD;
            bit_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                bridge_adc_pkg::ST_CMD: begin
                    if (sclk_rise) begin
                        rx_reg      <= {rx_reg[WB-2:0], sin_level};
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                    if (cmd_done) begin
                        bit_cnt_reg <= '0;
                        sel_reg     <= cmd_word[2:0];
                        if (cmd_word[`CMD_WRITE_BIT]) begin
                            if (cmd_word[2:0] != `SEL_CONV
                                && cmd_word[2:0] <= `SEL_LAST) begin
                                state_reg <= bridge_adc_pkg::ST_WR;
                            end
                        end else if (cmd_word[2:0] == `SEL_CONV) begin
                            state_reg   <= bridge_adc_pkg::ST_WAIT;
                            rd_conv_reg <= 1'b1;
                        end else if (cmd_word[2:0] <= `SEL_LAST) begin
                            state_reg   <= bridge_adc_pkg::ST_RD;
                            rd_conv_reg <= 1'b0;
                            tx_reg      <= cal_reg[cmd_word[2:0]];
                        end
                    end
                end
                bridge_adc_pkg::ST_WR: begin
                    if (sclk_rise && bit_cnt_reg != 5'(WB)) begin
                        rx_reg      <= {rx_reg[WB-2:0], sin_level};
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                    if (wr_commit) begin
                        state_reg   <= bridge_adc_pkg::ST_CMD;
                        bit_cnt_reg <= '0;
                    end
                end
                bridge_adc_pkg::ST_RD: begin
                    // Count sampling rises; the fall that closes the
                    // command byte must not push the first bit out unseen
                    if (sclk_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                    if (sclk_fall && bit_cnt_reg != 5'd0) begin
                        tx_reg <= {tx_reg[WB-2:0], 1'b0};
                    end
                    if (rd_done) begin
                        state_reg   <= bridge_adc_pkg::ST_CMD;
                        bit_cnt_reg <= '0;
                        rd_conv_reg <= 1'b0;
                    end
                end
                bridge_adc_pkg::ST_WAIT: begin
                    bit_cnt_reg <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration and configuration storage

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 1; i <= 6; i++) begin
                cal_reg[i] <= (i == 2) ? `GAIN_RESET : `CAL_RESET;
            end
        end else if (wr_commit) begin
            cal_reg[sel_reg] <= rx_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data ready

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_ready_n_n_reg <= 1'b1;
        end else if (asleep || cal_busy || load_evt) begin
            data_ready_n_n_reg <= 1'b1;
        end else if (take) begin
            data_ready_n_n_reg <= 1'b0;
        end else if (rd_done && rd_conv_reg) begin
            data_ready_n_n_reg <= 1'b1;
        end
    end

    assign data_ready_n = data_ready_n_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // Serial output

    // Enable follows the synchronised select, so it trails the pin by
    // the synchroniser latency; host must allow for it before sampling
    assign serial_out      = tx_reg[WB-1];
    assign serial_out_oe_n = ~(three_wire
                             | (selected
                               & (state_reg == bridge_adc_pkg::ST_RD)));

    ////////////////////////////////////////////////////////////////////////
    // Local register port and interrupt

    always_comb begin
        events = '0;
        events[`EVT_LOADED] = load_evt;
        events[`EVT_READ]   = rd_done;
        events[`EVT_CMD]    = cmd_done;
        events[`EVT_CONFIG] = wr_commit & (sel_reg == `SEL_CONFIG);
    end

    // A new event in the cycle of its clear keeps the bit set
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_reg <= '0;
        end else if (reg_we && reg_addr == `ADDR_IRQ_STATUS) begin
            status_reg <= (status_reg & ~reg_wdata[`EVT_COUNT-1:0])
                        | events;
        end else begin
            status_reg <= status_reg | events;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= '0;
        end else if (reg_we && reg_addr == `ADDR_IRQ_MASK) begin
            mask_reg <= reg_wdata[`EVT_COUNT-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sample_reg <= '0;
        end else if (reg_we && reg_addr == `ADDR_SAMPLE) begin
            sample_reg <= reg_wdata[RES-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_re) begin
            unique case (reg_addr)
                `ADDR_IRQ_STATUS: reg_rdata <= 32'(status_reg);
                `ADDR_IRQ_MASK:   reg_rdata <= 32'(mask_reg);
                `ADDR_SAMPLE:     reg_rdata <= 32'(sample_reg);
                `ADDR_STATE:      reg_rdata <= {20'h00000, state_reg,
                                                three_wire, data_ready_n_n_reg,
                                                fresh_reg, rd_conv_reg,
                                                cfg};
                default:          reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    assign irq = |(status_reg & mask_reg);

endmodule // bridge_adc_serial_port

// *** core/bridge_adc_defines.svh ***
// Constants for the bridge converter serial port: offsets, field positions,
// reset values and timing counts. Included by bare name; no logic here.
`ifndef BRIDGE_ADC_DEFINES_SVH
`define BRIDGE_ADC_DEFINES_SVH

// Conversion period in master clock cycles, output resolution, frame sizes
`define CONV_PERIOD      81920
`define RES_BITS         20
`define WORD_BITS        24
`define CMD_BITS         8

// Command byte layout: write flag and register select
`define CMD_WRITE_BIT    7
`define SEL_CONV         3'h0
`define SEL_CONFIG       3'h1
`define SEL_GAIN         3'h2
`define SEL_LAST         3'h6

// Configuration word fields and calibration reset values
`define CFG_SLEEP        0
`define CFG_FILTER_RESET 1
`define CFG_POLARITY     2
`define CFG_CAL_RUN      3
`define GAIN_RESET       24'h400000
`define CAL_RESET        24'h000000

// Pin positions in the synchronised pin bundle
`define PIN_SCLK         0
`define PIN_SEL_N        1
`define PIN_SIN          2
`define PIN_MCLK         3
`define PIN_MODE         4
`define PIN_COUNT        5

// Local register port byte offsets
`define ADDR_IRQ_STATUS  4'h0
`define ADDR_IRQ_MASK    4'h4
`define ADDR_SAMPLE      4'h8
`define ADDR_STATE       4'hc

// Interrupt event bits
`define EVT_LOADED       0
`define EVT_READ         1
`define EVT_CMD          2
`define EVT_CONFIG       3
`define EVT_COUNT        4

`endif

// *** core/bridge_adc_pkg.sv ***
// Types shared by the bridge converter serial port files.
// Assumes nothing of its surroundings.
package bridge_adc_pkg;

    // Serial port sequencer, one-hot
    typedef enum logic [3:0] {
        ST_CMD  = 4'b0001,
        ST_WR   = 4'b0010,
        ST_RD   = 4'b0100,
        ST_WAIT = 4'b1000
    } port_state_type;

endpackage

// *** core/link_pins_if.sv ***
// Carrier for synchronised pin levels and their edges.
// Assumes one clock domain; the synchroniser drives, the core reads.
`timescale 1ns/100ps
interface link_pins_if #(
    parameter int unsigned WIDTH = 5
);
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;

    modport sync (output level, output rise, output fall);
    modport core (input level, input rise, input fall);
endinterface

// *** core/pin_sync.sv ***
// Three-flop pin synchroniser with edge pulses.
// Assumes raw inputs are asynchronous to clk.
`timescale 1ns/100ps
module pin_sync #(
    parameter int unsigned WIDTH = 5
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] raw,
    link_pins_if.sync             pins
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] agree;

    // A change counts only once stages two and three agree
    assign agree = ~(s2_reg ^ s3_reg);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level_reg <= '0;
        end else begin
            level_reg <= (s2_reg & agree) | (level_reg & ~agree);
        end
    end

    assign pins.level = level_reg;
    assign pins.rise  = s2_reg & agree & ~level_reg;
    assign pins.fall  = ~s2_reg & agree & level_reg;

endmodule // pin_sync

// *** dv/bridge_adc_serial_port_props.sv ***
// Concurrent checks on the converter serial port and register port.
// Assumes a bind to the top module; sees only its ports.
`timescale 1ns/100ps
module bridge_adc_serial_port_props #(
    parameter int unsigned CONV_PERIOD = 81920
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        sclk,
    input wire logic        chip_select_n,
    input wire logic        serial_in,
    input wire logic        master_clock_in,
    input wire logic        port_wire_mode,
    input wire logic        serial_out,
    input wire logic        serial_out_oe_n,
    input wire logic        data_ready_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_we,
    input wire logic        reg_re,
    input wire logic [31:0] reg_rdata,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic [1:0]  pins_reg;
    logic [3:0]  age_reg;
    logic [1:0]  after_rst_reg;
    logic        mclk_reg;
    logic        data_ready_n_reg;
    int unsigned mclk_cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Cycles since a framing pin moved; covers synchroniser lag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pins_reg <= 2'h1;
            age_reg  <= 4'hf;
        end else begin
            pins_reg <= {sclk, chip_select_n};
            if (pins_reg != {sclk, chip_select_n})
                age_reg <= 4'h0;
            else if (age_reg != 4'hf)
                age_reg <= age_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            after_rst_reg <= 2'h0;
        else if (after_rst_reg != 2'h3)
            after_rst_reg <= after_rst_reg + 2'h1;
    end

    // Raw master clock rises since data ready last fell; slack of two for lag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mclk_reg     <= 1'b0;
            data_ready_n_reg     <= 1'b1;
            mclk_cnt_reg <= 0;
        end else begin
            mclk_reg <= master_clock_in;
            data_ready_n_reg <= data_ready_n;
            if (data_ready_n_reg && !data_ready_n)
                mclk_cnt_reg <= 0;
            else if (master_clock_in && !mclk_reg)
                mclk_cnt_reg <= mclk_cnt_reg + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_reset_quiet: assert property (
        after_rst_reg < 2'h2 |-> data_ready_n && serial_out_oe_n
            && reg_rdata == 32'h0 && !irq && !serial_out)
        else $error("outputs not quiet after reset");
    chk_deselect_hiz: assert property (
        (!port_wire_mode && chip_select_n) [*6] |-> serial_out_oe_n)
        else $error("serial out driven while deselected");
    chk_out_paced: assert property (
        $changed(serial_out) |-> age_reg <= 4'h8 || $fell(data_ready_n))
        else $error("serial out moved without serial clock");
    chk_three_wire_on: assert property (
        port_wire_mode [*6] |-> !serial_out_oe_n)
        else $error("serial out released in three wire mode");
    chk_data_ready_n_period: assert property (
        $fell(data_ready_n) |-> mclk_cnt_reg + 2 >= CONV_PERIOD)
        else $error("data ready fell before a full period");
    chk_rdata_idle: assert property (
        !$past(reg_re) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    chk_unmapped_rd: assert property (
        reg_re && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    chk_state_snap: assert property (
        reg_re && reg_addr == 4'hc |=> reg_rdata[6] == $past(data_ready_n)
            && reg_rdata[31:12] == 20'h0)
        else $error("state word disagrees with data ready");
    chk_mask_quiet: assert property (
        reg_we && reg_addr == 4'h4 && reg_wdata[3:0] == 4'h0 |=> !irq)
        else $error("interrupt high with all events masked");

    cov_word_loaded: cover property ($fell(data_ready_n));
    cov_irq_raised: cover property ($rose(irq));
    cov_three_wire: cover property (port_wire_mode && !serial_out_oe_n);
endmodule // bridge_adc_serial_port_props

// *** dv/serial_host_model.sv ***
// Behavioural microcontroller on the far side of the serial port.
// Assumes the bench calls xfer; the serial clock stands low between frames.
`timescale 1ns/100ps
module serial_host_model (
    output logic      sclk,
    output logic      chip_select_n,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe_n,
    input  wire logic data_ready_n
);
    logic idle  = 1'b1;
    logic cs_en = 1'b1;
    wire  sdo_pin = serial_out_oe_n ? 1'bz : serial_out;

    initial begin
        sclk          = 1'b0;
        chip_select_n = 1'b1;
        serial_in     = 1'b0;
    end

    // Data pin is unowned outside words, so it toggles to expose misuse
    always #7 if (idle) serial_in = ~serial_in;

    ////////////////////////////////////////////////////////////////////////
    // Frame of n clocks; n below 32 stops early to abort the word
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                        input bit wt, input int n, output logic [23:0] rd);
        logic [31:0] w;
        logic        q;
        int          k;
        w             = {cmd, wd};
        rd            = 24'h0;
        idle          = 1'b0;
        chip_select_n = ~cs_en;
        #30;
        for (int j = 0; j < n; j++) begin
            if (j == 8 && wt) begin
                k = 0;
                while (data_ready_n !== 1'b0 && k < 4000) begin
                    #10;
                    k++;
                end
            end
            serial_in = w[31-j];
            #24 sclk = 1'b1;
            q = sdo_pin;
            #24 sclk = 1'b0;
            if (j >= 8)
                rd[31-j] = q;
        end
        #30;
        chip_select_n = 1'b1;
        idle          = 1'b1;
        #30;
    endtask
endmodule // serial_host_model

// *** dv/bridge_adc_serial_port_tb_top.sv ***
// Self-checking bench for the converter serial port.
// Assumes the host model drives the link pins and the bench the registers.
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    errors++; $display("CHECK FAILED at %0t: got %0h expected %0h", \
    $time, (got), (exp)); end end
module bridge_adc_serial_port_tb_top;
    localparam int unsigned PERIOD = 16;
    logic        clk = 1'b0, rstn = 1'b0, master_clock_in = 1'b0;
    logic        port_wire_mode = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic        sclk, chip_select_n, serial_in, serial_out;
    logic        serial_out_oe_n, data_ready_n, irq;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
    logic [23:0] d;
    int          errors = 0, checks_done = 0, raw;
    int          cal_m [7];
    bit          pol;

    always #2 clk = ~clk;
    always #20 master_clock_in = ~master_clock_in;

    bridge_adc_serial_port #(.CONV_PERIOD(PERIOD), .RES(20))
        i_bridge_adc_serial_port (.clk, .rstn, .sclk, .chip_select_n,
        .serial_in, .master_clock_in, .port_wire_mode, .serial_out,
        .serial_out_oe_n, .data_ready_n, .reg_addr, .reg_wdata, .reg_we,
        .reg_re, .reg_rdata, .irq);
    serial_host_model i_host (.sclk, .chip_select_n, .serial_in,
        .serial_out, .serial_out_oe_n, .data_ready_n);

    ////////////////////////////////////////////////////////////////////////
    function automatic int code(int r, bit b);
        if (b)
            return (r ^ 20'h80000) << 4;
        return r[19] ? 0 : r << 5;
    endfunction

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        give_verdict;
    end

    initial begin
        void'($urandom(32'h47ed));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(4'hc, rv);
        `CHK(rv, 32'h140)
        rd_reg(4'h2, rv);
        `CHK(rv, 32'h0)
        cal_m = '{0, 0, 24'h400000, 0, 0, 0, 0};
        for (int s = 1; s < 7; s++) begin
            i_host.xfer(8'(s), 24'($urandom), 1'b0, 32, d);
            `CHK(d, cal_m[s])
        end
        for (int s = 1; s < 7; s++) begin
            cal_m[s] = (s == 1) ? 1 : int'($urandom & 24'hffffff);
            i_host.xfer(8'h80 | 8'(s), 24'(cal_m[s]), 1'b0, 32, d);
        end
        for (int s = 1; s < 7; s++) begin
            i_host.xfer(8'(s), 24'($urandom), 1'b0, 32, d);
            `CHK(d, cal_m[s])
        end
        // Deselect mid-command must drop the partial word
        i_host.xfer(8'h81, 24'h0, 1'b0, 5, d);
        i_host.xfer(8'h02, 24'($urandom), 1'b0, 32, d);
        `CHK(d, cal_m[2])
        wr_reg(4'h0, 32'hf);
        wr_reg(4'h4, 32'hf);
        i_host.xfer(8'h81, 24'h4, 1'b0, 32, d);
        rd_reg(4'h0, rv);
        `CHK(rv, 32'hc)
        `CHK(irq, 1'b1)
        wr_reg(4'h4, 32'h0);
        `CHK(irq, 1'b0)
        wr_reg(4'h0, 32'hc);
        rd_reg(4'h0, rv);
        `CHK(rv, 32'h0)
        for (int i = 0; i < 4; i++) begin
            pol = (i % 2 == 0);
            raw = int'($urandom & 20'h7ffff);
            if (i > 1)
                raw = raw | 20'h80000;
            if (i == 0)
                raw = 0;
            wr_reg(4'h8, 32'(raw));
            i_host.xfer(8'h81, 24'(pol * 4 + 2), 1'b0, 32, d);
            i_host.xfer(8'h81, 24'(pol * 4), 1'b0, 32, d);
            i_host.xfer(8'h00, 24'($urandom), 1'b1, 32, d);
            `CHK(d, code(raw, pol))
            `CHK(data_ready_n, 1'b1)
        end
        @(posedge clk);
        port_wire_mode <= 1'b1;
        i_host.cs_en = 1'b0;
        repeat (8) @(posedge clk);
        `CHK(serial_out_oe_n, 1'b0)
        i_host.xfer(8'h02, 24'($urandom), 1'b0, 32, d);
        `CHK(d, cal_m[2])
        @(posedge clk);
        port_wire_mode <= 1'b0;
        i_host.cs_en = 1'b1;
        repeat (8) @(posedge clk);
        `CHK(serial_out_oe_n, 1'b1)
        give_verdict;
    end
endmodule // bridge_adc_serial_port_tb_top

bind bridge_adc_serial_port bridge_adc_serial_port_props #(
    .CONV_PERIOD(CONV_PERIOD)
) i_bridge_adc_serial_port_props (.clk, .rstn, .sclk, .chip_select_n,
    .serial_in, .master_clock_in, .port_wire_mode, .serial_out,
    .serial_out_oe_n, .data_ready_n, .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .irq);
